// File: ddsl_map.svh
`ifndef DDSL_MAP_SVH
`define DDSL_MAP_SVH

// Serial command word layout.
`define DDSL_CMD_BITS        16
`define DDSL_CHAN_BIT        15
`define DDSL_GAIN_BIT        13
`define DDSL_ACT_BIT         12
`define DDSL_DATA_BITS       12

// Register byte offsets on the APB port.
`define DDSL_OFS_CTRL        8'h00
`define DDSL_OFS_IN_A        8'h04
`define DDSL_OFS_IN_B        8'h08
`define DDSL_OFS_OUT_A       8'h0c
`define DDSL_OFS_OUT_B       8'h10
`define DDSL_OFS_STAT        8'h14

// Control register fields.
`define DDSL_CTRL_LATCH_BIT  0
`define DDSL_CTRL_PINOFF_BIT 1

// Status register fields.
`define DDSL_STAT_ABORT_LSB  8
`define DDSL_STAT_PIN_BIT    16

// Reset values.
`define DDSL_CHAN_RST        14'h0000
`define DDSL_RX_SYNC_RST     3'h1
`define DDSL_LATCH_SYNC_RST  2'h3
`define DDSL_CNT_RST         8'h00

`endif

// File: ddsl_pkg.sv
package ddsl_pkg;

   typedef struct packed {
      logic        unity;
      logic        active;
      logic [11:0] code;
   } ddsl_chan_t;

   typedef enum logic [1:0] {
      RX_IDLE,
      RX_SHIFT,
      RX_FULL
   } ddsl_rx_state_t;

endpackage

// File: ddsl_word_if.sv
`timescale 1ns/1ps
interface ddsl_word_if;
   logic        valid;
   logic        abort;
   logic [15:0] word;

   modport src (output valid, output abort, output word);
   modport dst (input valid, input abort, input word);
endinterface

// File: ddsl_shift.sv
`timescale 1ns/1ps
`include "ddsl_map.svh"
module ddsl_shift
   import ddsl_pkg::*;
(
   input  wire logic pclk,    // System clock.
   input  wire logic presetn, // Asynchronous reset, active low.
   input  wire logic cs_n,    // Select pin, asynchronous.
   input  wire logic sck,     // Serial clock pin, asynchronous.
   input  wire logic sdi,     // Serial data pin, asynchronous.
   ddsl_word_if.src  wif      // Finished or discarded command frames.
);

   // Bit order in both stages: sdi, sck, cs_n.
   logic [2:0]     meta_r;
   logic [2:0]     sync_r;
   logic           sck_d_r;
   logic           cs_lo;
   logic           sck_rise;
   ddsl_rx_state_t st_r, st_nxt;
   logic [4:0]     cnt_r, cnt_nxt;
   logic [15:0]    shr_r, shr_nxt;
   logic [15:0]    word_r, word_nxt;
   logic           valid_r, valid_nxt;
   logic           abort_r, abort_nxt;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         meta_r  <= `DDSL_RX_SYNC_RST;
         sync_r  <= `DDSL_RX_SYNC_RST;
         sck_d_r <= 1'b0;
      end else begin
         meta_r  <= {sdi, sck, cs_n};
         sync_r  <= meta_r;
         sck_d_r <= sync_r[1];
      end
   end

   assign cs_lo    = !sync_r[0];
   assign sck_rise = sync_r[1] && !sck_d_r;

   always_comb begin
      st_nxt    = st_r;
      cnt_nxt   = cnt_r;
      shr_nxt   = shr_r;
      word_nxt  = word_r;
      valid_nxt = 1'b0;
      abort_nxt = 1'b0;
      if (!cs_lo) begin
         cnt_nxt = 5'h00;                                    // [R1]
         st_nxt  = RX_IDLE;
      end
      unique case (st_r)
         RX_IDLE: begin
            if (cs_lo) begin
               st_nxt = RX_SHIFT;
            end
         end
         RX_SHIFT: begin
            if (!cs_lo) begin
               abort_nxt = (cnt_r != 5'h00);                 // [R10]
            end else if (sck_rise) begin
               shr_nxt = {shr_r[14:0], sync_r[2]};           // [R7] [R8]
               cnt_nxt = cnt_r + 5'h01;
               if (cnt_r == 5'(`DDSL_CMD_BITS - 1)) begin
                  st_nxt = RX_FULL;
               end
            end
         end
         RX_FULL: begin
            // Further clocks are ignored until select rises.
            if (!cs_lo) begin
               valid_nxt = 1'b1;                             // [R10]
               word_nxt  = shr_r;
            end
         end
         // The fourth state code is never entered; recover to idle if it is.
         default: begin
            st_nxt = RX_IDLE;
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_r    <= RX_IDLE;
         cnt_r   <= 5'h00;
         shr_r   <= 16'h0000;
         word_r  <= 16'h0000;
         valid_r <= 1'b0;
         abort_r <= 1'b0;
      end else begin
         st_r    <= st_nxt;
         cnt_r   <= cnt_nxt;
         shr_r   <= shr_nxt;
         word_r  <= word_nxt;
         valid_r <= valid_nxt;
         abort_r <= abort_nxt;
      end
   end

   assign wif.valid = valid_r;
   assign wif.abort = abort_r;
   assign wif.word  = word_r;

   default clocking rx_cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sel_gate_a: assert property (!cs_lo |=> cnt_r == 5'h00)   // [R1]
      else $error("bit count not cleared while select is high");
   count_cap_a: assert property (cnt_r <= 5'h10)             // [R10]
      else $error("bit count passed sixteen");
   early_drop_a: assert property (st_r == RX_SHIFT && !cs_lo |=> !wif.valid) // [R10]
      else $error("short frame was committed");
   full_only_a: assert property (wif.valid |-> $past(st_r) == RX_FULL) // [R8]
      else $error("frame committed without sixteen clocks");
   rise_sample_a: assert property (st_r == RX_SHIFT && cs_lo && sck_rise
      |=> shr_r[0] == $past(sync_r[2]))                     // [R7]
      else $error("data not sampled at serial clock rise");

endmodule

// File: ddsl_top.sv
// Function
// R1: Serial clock and data are accepted only while select is low.
// R2: Latch pin low copies both input registers to output registers together.
// R3: Latch pin held low updates the written channel when a valid frame ends.
// R4: The code is straight unsigned binary, zero gives lowest output.
// R5: Code width is 8, 10 or 12 bits, same for both channels.
// R6: Each channel keeps its own unity or double gain setting.
// R7: Data is sampled on each rising edge of the serial clock.
// R8: Frames are 16 bits MSB first, four configuration then twelve data bits.
// R9: Bit 15 picks channel, 14 ignored, 13 unity gain, 12 active.
// R10: Commit needs exactly sixteen clocks then select rising; extras ignored.
// R11: After reset both channels are shut down with cleared output registers.
//
// The register offsets and the APB register port were left to the implementer.
`timescale 1ns/1ps
`include "ddsl_map.svh"
module ddsl_top
   import ddsl_pkg::*;
#(
   parameter int RES_BITS = 12                    // Code width: 8, 10 or 12.
)(
   input  wire logic                pclk,                   // System clock, 10 MHz.
   input  wire logic                presetn,                // Asynchronous reset, active low.
   input  wire logic                psel,                   // APB select.
   input  wire logic                penable,                // APB enable.
   input  wire logic                pwrite,                 // APB direction, high for write.
   input  wire logic [7:0]          paddr,                  // APB byte address.
   input  wire logic [31:0]         pwdata,                 // APB write data.
   output logic      [31:0]         prdata,                 // APB read data.
   output logic                     pready,                 // APB ready.
   output logic                     pslverr,                // APB error on unmapped address.
   input  wire logic                cs_n,                   // Serial select, active low.
   input  wire logic                sck,                    // Serial clock.
   input  wire logic                sdi,                    // Serial data.
   input  wire logic                latch_sync_n,           // Output update pin, active low.
   output logic      [RES_BITS-1:0] analog_out_first_code,  // Channel A output code.
   output logic                     analog_out_first_unity, // Channel A gain is unity.
   output logic                     analog_out_first_active,// Channel A is powered.
   output logic      [RES_BITS-1:0] analog_out_second_code, // Channel B output code.
   output logic                     analog_out_second_unity,// Channel B gain is unity.
   output logic                     analog_out_second_active// Channel B is powered.
);

   ddsl_word_if wif ();

   ddsl_shift u_shift (
      .pclk    (pclk),
      .presetn (presetn),
      .cs_n    (cs_n),
      .sck     (sck),
      .sdi     (sdi),
      .wif     (wif)
   );

   function automatic ddsl_chan_t decode(input logic [15:0] w);
      ddsl_chan_t c;
      c        = 14'(`DDSL_CHAN_RST);
      c.unity  = w[`DDSL_GAIN_BIT];                              // [R6] [R9]
      c.active = w[`DDSL_ACT_BIT];                               // [R9]
      // Narrow variants drop the unused low bits of the left-justified data.
      c.code   = 12'(w[`DDSL_DATA_BITS-1:0] >> (`DDSL_DATA_BITS - RES_BITS)); // [R4] [R5] [R8]
      return c;
   endfunction

   function automatic logic [31:0] show_chan(input ddsl_chan_t c);
      return {18'h00000, c.unity, c.active, c.code};
   endfunction

   function automatic logic addr_hit(input logic [7:0] a);
      return (a == `DDSL_OFS_CTRL) || (a == `DDSL_OFS_IN_A) || (a == `DDSL_OFS_IN_B)
          || (a == `DDSL_OFS_OUT_A) || (a == `DDSL_OFS_OUT_B) || (a == `DDSL_OFS_STAT);
   endfunction

   logic [1:0]  lmeta_r;
   logic [1:0]  lsync_r;
   logic        latch_lo;
   logic        apb_setup;
   logic        apb_wr;
   logic        ctrl_wr;
   logic        sw_latch;
   logic        latch_go;
   ddsl_chan_t  cmd_dec;
   ddsl_chan_t  in_a_r, in_a_nxt;
   ddsl_chan_t  in_b_r, in_b_nxt;
   ddsl_chan_t  out_a_r, out_a_nxt;
   ddsl_chan_t  out_b_r, out_b_nxt;
   logic        pin_off_r, pin_off_nxt;
   logic [7:0]  commit_cnt_r, commit_cnt_nxt;
   logic [7:0]  abort_cnt_r, abort_cnt_nxt;
   logic [31:0] prdata_r, prdata_nxt;

   // The latch pin is asynchronous to pclk and passes two flops first.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         lmeta_r <= `DDSL_LATCH_SYNC_RST;
      end else begin
         lmeta_r <= {lmeta_r[0], latch_sync_n};
      end
   end

   assign lsync_r  = lmeta_r;
   assign latch_lo = !lsync_r[1];

   // APB: zero wait states; read data is captured in the setup cycle.
   assign apb_setup = psel && !penable;
   assign pready    = 1'b1;
   assign pslverr   = psel && penable && !addr_hit(paddr);
   assign apb_wr    = psel && penable && pready && pwrite;
   assign ctrl_wr   = apb_wr && (paddr == `DDSL_OFS_CTRL);
   assign sw_latch  = ctrl_wr && pwdata[`DDSL_CTRL_LATCH_BIT];
   assign latch_go  = (latch_lo && !pin_off_r) || sw_latch;          // [R2]
   assign cmd_dec   = decode(wif.word);

   always_comb begin
      in_a_nxt       = in_a_r;
      in_b_nxt       = in_b_r;
      out_a_nxt      = out_a_r;
      out_b_nxt      = out_b_r;
      pin_off_nxt    = pin_off_r;
      commit_cnt_nxt = commit_cnt_r;
      abort_cnt_nxt  = abort_cnt_r;
      if (wif.valid) begin
         if (wif.word[`DDSL_CHAN_BIT]) begin                          // [R9]
            in_b_nxt = cmd_dec;
         end else begin
            in_a_nxt = cmd_dec;
         end
         commit_cnt_nxt = commit_cnt_r + 8'h01;
      end
      if (wif.abort) begin
         abort_cnt_nxt = abort_cnt_r + 8'h01;
      end
      // While the pin stays low the output follows each commit one cycle after the input register.
      if (latch_go) begin
         out_a_nxt = in_a_r;                                          // [R2] [R3]
         out_b_nxt = in_b_r;
      end
      if (ctrl_wr) begin
         pin_off_nxt = pwdata[`DDSL_CTRL_PINOFF_BIT];
      end
   end

   always_comb begin
      prdata_nxt = prdata_r;
      if (apb_setup) begin
         prdata_nxt = 32'h00000000;
         if (!pwrite) begin
            unique case (paddr)
               `DDSL_OFS_CTRL:  prdata_nxt[`DDSL_CTRL_PINOFF_BIT] = pin_off_r;
               `DDSL_OFS_IN_A:  prdata_nxt = show_chan(in_a_r);
               `DDSL_OFS_IN_B:  prdata_nxt = show_chan(in_b_r);
               `DDSL_OFS_OUT_A: prdata_nxt = show_chan(out_a_r);
               `DDSL_OFS_OUT_B: prdata_nxt = show_chan(out_b_r);
               `DDSL_OFS_STAT: begin
                  prdata_nxt[7:0]                    = commit_cnt_r;
                  prdata_nxt[`DDSL_STAT_ABORT_LSB+:8] = abort_cnt_r;
                  prdata_nxt[`DDSL_STAT_PIN_BIT]      = latch_lo;
               end
               default: prdata_nxt = 32'h00000000;
            endcase
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         in_a_r       <= `DDSL_CHAN_RST;                              // [R11]
         in_b_r       <= `DDSL_CHAN_RST;
         out_a_r      <= `DDSL_CHAN_RST;
         out_b_r      <= `DDSL_CHAN_RST;
         pin_off_r    <= 1'b0;
         commit_cnt_r <= `DDSL_CNT_RST;
         abort_cnt_r  <= `DDSL_CNT_RST;
         prdata_r     <= 32'h00000000;
      end else begin
         in_a_r       <= in_a_nxt;
         in_b_r       <= in_b_nxt;
         out_a_r      <= out_a_nxt;
         out_b_r      <= out_b_nxt;
         pin_off_r    <= pin_off_nxt;
         commit_cnt_r <= commit_cnt_nxt;
         abort_cnt_r  <= abort_cnt_nxt;
         prdata_r     <= prdata_nxt;
      end
   end

   assign prdata                   = prdata_r;
   assign analog_out_first_code    = out_a_r.code[RES_BITS-1:0];      // [R4] [R5]
   assign analog_out_first_unity   = out_a_r.unity;                   // [R6]
   assign analog_out_first_active  = out_a_r.active;
   assign analog_out_second_code   = out_b_r.code[RES_BITS-1:0];
   assign analog_out_second_unity  = out_b_r.unity;
   assign analog_out_second_active = out_b_r.active;

   default clocking top_cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence cmd_to_a_s;
      wif.valid && !wif.word[`DDSL_CHAN_BIT];
   endsequence

   sequence pin_held_s;
      (latch_lo && !pin_off_r) [*2];
   endsequence

   latch_copy_a: assert property (latch_go |=>                       // [R2]
      out_a_r == $past(in_a_r) && out_b_r == $past(in_b_r))
      else $error("outputs did not take both input registers");
   out_hold_a: assert property (!latch_go |=>                        // [R2]
      $stable(out_a_r) && $stable(out_b_r))
      else $error("output register changed without latch");
   tied_update_a: assert property (cmd_to_a_s ##0 pin_held_s |=>    // [R3]
      out_a_r == decode($past(wif.word, 2)))
      else $error("held latch did not update written channel");
   code_binary_a: assert property (cmd_to_a_s |=>                    // [R4]
      in_a_r.code == 12'($past(wif.word[11:0]) >> (12 - RES_BITS)))
      else $error("code not taken as straight binary");
   code_width_a: assert property (                                   // [R5]
      (out_a_r.code >> RES_BITS) == 12'h000 && (out_b_r.code >> RES_BITS) == 12'h000)
      else $error("output code wider than resolution");
   gain_own_a: assert property (cmd_to_a_s |=>                       // [R6]
      in_a_r.unity == $past(wif.word[13]) && $stable(in_b_r))
      else $error("gain not kept per channel");
   route_b_a: assert property (wif.valid && wif.word[`DDSL_CHAN_BIT] |=> // [R9]
      in_b_r == decode($past(wif.word)) && $stable(in_a_r))
      else $error("channel B command misrouted");
   wake_cause_a: assert property ($rose(out_a_r.active) |-> $past(latch_go)) // [R11]
      else $error("channel left shutdown without a latch");

endmodule

// File: ddsl_host.sv
`timescale 1ns/1ps
module ddsl_host (
   input  wire logic pclk,        // System clock, paces the host.
   output logic      cs_n,        // Select, active low.
   output logic      sck,         // Serial clock.
   output logic      sdi,         // Serial data.
   output logic      latch_sync_n // Output update pin, active low.
);
   initial begin
      cs_n = 1'b1;
      sck = 1'b0;
      sdi = 1'b0;
      latch_sync_n = 1'b1;
   end

   task automatic wt(input int n);
      repeat (n) @(posedge pclk);
   endtask

   // One frame of n clocks; bits past the sixteenth carry junk on purpose.
   task automatic send(input logic [15:0] w, input int n, input logic cpol);
      int i;
      sck <= cpol;
      wt(2);
      cs_n <= 1'b0;
      wt(2);
      for (i = 0; i < n; i++) begin
         sck <= 1'b0;
         sdi <= (i < 16) ? w[15-i] : ~sdi;
         wt(4);
         sck <= 1'b1;
         wt(4);
      end
      sck <= cpol;
      wt(2);
      cs_n <= 1'b1;
      sdi <= ~sdi;
      wt(8);
   endtask

   // Clocks with select high must leave no trace in the device.
   task automatic idle_clk(input int n);
      int i;
      for (i = 0; i < n; i++) begin
         sck <= 1'b1;
         sdi <= ~sdi;
         wt(4);
         sck <= 1'b0;
         wt(4);
      end
   endtask

   task automatic pulse(input int n);
      latch_sync_n <= 1'b0;
      wt(n);
      latch_sync_n <= 1'b1;
      wt(2);
   endtask

   task automatic hold(input logic v);
      latch_sync_n <= v;
      wt(4);
   endtask
endmodule

// File: tb.sv
`timescale 1ns/1ps
`include "ddsl_map.svh"
module tb;
   logic        pclk, presetn, psel, penable, pwrite;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rd;
   logic        pready, pslverr, err;
   logic        cs_n, sck, sdi, latch_sync_n;
   logic [11:0] analog_out_first_code, analog_out_second_code;
   logic        analog_out_first_unity, analog_out_first_active;
   logic        analog_out_second_unity, analog_out_second_active;
   logic [13:0] oa, ob;
   logic [7:0]  n8_code_a, n8_code_b;
   int          mismatches, check_count;

   assign oa = {analog_out_first_unity, analog_out_first_active, analog_out_first_code};
   assign ob = {analog_out_second_unity, analog_out_second_active, analog_out_second_code};

   ddsl_top #(.RES_BITS(12)) u_dut (
      .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
      .pslverr, .cs_n, .sck, .sdi, .latch_sync_n, .analog_out_first_code,
      .analog_out_first_unity, .analog_out_first_active, .analog_out_second_code,
      .analog_out_second_unity, .analog_out_second_active
   );

   // A narrow variant on the same pins shows that the low data bits are dropped.
   ddsl_top #(.RES_BITS(8)) u_dut8 (
      .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata(), .pready(), .pslverr(), .cs_n, .sck, .sdi, .latch_sync_n,
      .analog_out_first_code(n8_code_a), .analog_out_first_unity(),
      .analog_out_first_active(), .analog_out_second_code(n8_code_b),
      .analog_out_second_unity(), .analog_out_second_active()
   );

   ddsl_host u_host (.pclk, .cs_n, .sck, .sdi, .latch_sync_n);

   initial pclk = 1'b0;
   always #50 pclk = ~pclk;

   task automatic report_and_stop;
      if (mismatches == 0 && check_count > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      check_count++;
      if (g !== e) begin
         mismatches++;
         $display("FAIL %s expected %h seen %h", nm, e, g);
      end
   endtask

   // Entered just after a rising edge; returns one idle cycle after the answer.
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int i;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      for (i = 0; i < 20; i++) begin
         @(posedge pclk);
         if (pready === 1'b1) break;
      end
      if (i == 20) begin
         mismatches++;
         report_and_stop();
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask

   task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk("register read", e, rd);
   endtask

   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      mismatches = 0;
      check_count = 0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      chk("reset outputs", 32'h0, {oa, ob});
      rdchk(`DDSL_OFS_OUT_B, 32'h0);
      u_host.send(16'h3abc, 16, 1'b0);
      rdchk(`DDSL_OFS_IN_A, 32'h3abc);
      chk("no err", 32'h0, err);
      chk("double buffer", 32'h0, {oa, ob});
      u_host.send(16'hd123, 16, 1'b1);
      rdchk(`DDSL_OFS_IN_B, 32'h1123);
      u_host.pulse(5);
      chk("latched pair", {14'h3abc, 14'h1123}, {oa, ob});
      chk("narrow pair", {8'hab, 8'h12}, {n8_code_a, n8_code_b});
      u_host.send(16'h3fff, 10, 1'b0);
      rdchk(`DDSL_OFS_IN_A, 32'h3abc);
      u_host.send(16'h2005, 18, 1'b0);
      rdchk(`DDSL_OFS_IN_A, 32'h2005);
      rdchk(`DDSL_OFS_STAT, 32'h0103);
      apb(1'b1, `DDSL_OFS_CTRL, 32'h2);
      u_host.pulse(5);
      chk("pin ignored", {14'h3abc, 14'h1123}, {oa, ob});
      apb(1'b1, `DDSL_OFS_CTRL, 32'h3);
      chk("soft latch", {14'h2005, 14'h1123}, {oa, ob});
      rdchk(`DDSL_OFS_CTRL, 32'h2);
      apb(1'b1, `DDSL_OFS_CTRL, 32'h0);
      u_host.idle_clk(6);
      u_host.send(16'h9abc, 16, 1'b0);
      rdchk(`DDSL_OFS_IN_B, 32'h1abc);
      u_host.hold(1'b0);
      u_host.send(16'h1fff, 16, 1'b0);
      chk("follow a", {14'h1fff, 14'h1abc}, {oa, ob});
      chk("narrow follow", {8'hff, 8'hab}, {n8_code_a, n8_code_b});
      u_host.send(16'h9000, 16, 1'b0);
      chk("follow b", {14'h1fff, 14'h1000}, {oa, ob});
      rdchk(`DDSL_OFS_STAT, 32'h10106);
      apb(1'b1, `DDSL_OFS_IN_A, 32'hffff);
      rdchk(`DDSL_OFS_IN_A, 32'h1fff);
      apb(1'b0, 8'h40, 32'h0);
      chk("unmapped data", 32'h0, rd);
      chk("unmapped err", 32'h1, err);
      report_and_stop();
   end
endmodule
